// [src/sas_cfg.svh]
// Offsets, field positions, reset values and timing counts of the converter sequencer.
// Operation
// - Multi mode converts group once, then stops.
// - Scan mode repeats until start bit cleared.
// - Multi select 0 means single; scan picks multi/scan.
// - Time select 0 slow 536, 1 fast 266.
// - Channel codes 2..7; groups start at 2 or 4.
// - Both trigger enables: falling edge sets start.
// - Trigger start behaves like software start.
// - Reserved trigger register bits 4:3 read zero, 2:0 read one.
// - Trigger register resets to 07 and in standby.
// - Upper-byte read latches lower byte for later.
// - Single end: store, flag, clear start together.
// - Interrupt request equals flag and enable.
// - Flag clears by write 0 after reading 1.
// - Every restart begins at group first channel.
// - Next channel begins immediately after previous ends.
// - Scan end sets flag and wraps, start stays.
// - Start delay then sampling window of fixed length.
// - Later conversions last exactly 536 or 266 states.
// - First conversion lasts 514-525 or 259-266 states.
// - Inputs map to result registers A to D.
// - Result high byte, low two bits at 7:6.
// - DMA read of a result clears the flag.
// - Result registers clear on reset and standby.
`ifndef SAS_CFG_SVH
`define SAS_CFG_SVH

// Byte offsets of the registers on the peripheral bus.
`define SAS_OFF_RES_A_HI 8'h80
`define SAS_OFF_RES_A_LO 8'h82
`define SAS_OFF_CSR 8'h90
`define SAS_OFF_TRIG 8'h92
`define SAS_RES_BASE_NIB 4'h8

// Bit positions in the control/status register.
`define SAS_CSR_FLAG 7
`define SAS_CSR_IE 6
`define SAS_CSR_START 5
`define SAS_CSR_MULTI 4
`define SAS_CSR_CKS 3

// Bit positions in the trigger/scan control register.
`define SAS_TRIG_TE_HI 7
`define SAS_TRIG_TE_LO 6
`define SAS_TRIG_SCAN 5

// Reset values.
`define SAS_TRIG_RESET 8'h07
`define SAS_RESULT_RESET 10'h000

// One state is one peripheral clock period; the clock runs at 10 ns.
`define SAS_STATE_NS 10
`define SAS_CLK_NS 10
`define SAS_CYC(states) ((states) * `SAS_STATE_NS / `SAS_CLK_NS)

// Timing in states, turned into cycles.
`define SAS_DELAY_SLOW `SAS_CYC(17)
`define SAS_DELAY_FAST `SAS_CYC(10)
`define SAS_SAMPLE_SLOW `SAS_CYC(129)
`define SAS_SAMPLE_FAST `SAS_CYC(65)
`define SAS_FIRST_SLOW `SAS_CYC(520)
`define SAS_FIRST_FAST `SAS_CYC(262)
`define SAS_FULL_SLOW `SAS_CYC(536)
`define SAS_FULL_FAST `SAS_CYC(266)

`endif

// [src/sas_conv_timer.sv]
// Conversion timer: start delay, sampling window and conversion phase.
`timescale 1ns/1ps
`include "sas_cfg.svh"
module sas_conv_timer (
    input wire logic core_clk,
    input wire logic rst_b,
    sas_timer_if.tmr tif
);
    sas_pkg::sas_phase_t phase;      // Current phase.
    sas_pkg::sas_phase_t next_phase; // Phase for the next cycle.
    logic [9:0] cnt;                 // Cycles left in the phase, minus one.
    logic [9:0] next_cnt;            // Counter value for the next cycle.
    logic first;                     // Current conversion is the first after a start.
    logic next_first;                // First marker for the next cycle.

    // Turns a cycle count into the value loaded into the down counter.
    function automatic logic [9:0] loadOf(input int cycles);
        return 10'(cycles - 1);
    endfunction

    // Cycle counts for the current speed.
    wire [9:0] delayLoad = tif.fast ? loadOf(`SAS_DELAY_FAST) : loadOf(`SAS_DELAY_SLOW);
    wire [9:0] sampleLoad = tif.fast ? loadOf(`SAS_SAMPLE_FAST) : loadOf(`SAS_SAMPLE_SLOW);
    // The idle cycle and the delay count toward the first conversion.
    wire [9:0] firstRest = tif.fast
        ? loadOf(`SAS_FIRST_FAST - 1 - `SAS_DELAY_FAST - `SAS_SAMPLE_FAST)
        : loadOf(`SAS_FIRST_SLOW - 1 - `SAS_DELAY_SLOW - `SAS_SAMPLE_SLOW);
    wire [9:0] fullRest = tif.fast
        ? loadOf(`SAS_FULL_FAST - `SAS_SAMPLE_FAST)
        : loadOf(`SAS_FULL_SLOW - `SAS_SAMPLE_SLOW);
    wire cntZero = cnt == 10'h000;

    assign tif.idle = phase == sas_pkg::SAS_IDLE;
    assign tif.sampling = phase == sas_pkg::SAS_SAMPLE;
    assign tif.done = tif.go && phase == sas_pkg::SAS_CONVERT && cntZero;

    // Phase sequencing; dropping go aborts at once from any phase.
    always_comb begin
        next_phase = phase;
        next_cnt = cntZero ? cnt : 10'(cnt - 10'h001);
        next_first = first;
        case (phase)
            sas_pkg::SAS_IDLE: begin
                next_first = 1'b1;
                if (tif.go) begin
                    next_phase = sas_pkg::SAS_DELAY;
                    next_cnt = delayLoad;
                end
            end
            sas_pkg::SAS_DELAY: begin
                if (cntZero) begin
                    next_phase = sas_pkg::SAS_SAMPLE;
                    next_cnt = sampleLoad;
                end
            end
            sas_pkg::SAS_SAMPLE: begin
                if (cntZero) begin
                    next_phase = sas_pkg::SAS_CONVERT;
                    next_cnt = first ? firstRest : fullRest;
                end
            end
            sas_pkg::SAS_CONVERT: begin
                if (cntZero) begin
                    // The next channel starts sampling on the following cycle.
                    next_phase = sas_pkg::SAS_SAMPLE;
                    next_cnt = sampleLoad;
                    next_first = 1'b0;
                end
            end
            default: begin
                next_phase = sas_pkg::SAS_IDLE;
            end
        endcase
        if (!tif.go) begin
            next_phase = sas_pkg::SAS_IDLE;
            next_first = 1'b1;
        end
    end

    // Phase, counter and first marker registers.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            phase <= sas_pkg::SAS_IDLE;
            cnt <= 10'h000;
            first <= 1'b1;
        end else begin
            phase <= next_phase;
            cnt <= next_cnt;
            first <= next_first;
        end
    end

    default clocking tcb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // Sampling lasts well beyond a handful of cycles once it begins, unless aborted.
    sample_window_a: assert property (disable iff (!rst_b || !tif.go)
        $rose(tif.sampling) && tif.go |-> tif.sampling[*8])
        else $error("sampling window ended too early");
    // A start waits in the delay phase before sampling.
    start_delay_a: assert property (tif.idle && tif.go |=> !tif.sampling[*8])
        else $error("sampling began without start delay");
    // A finished conversion goes straight into the next sampling window.
    next_chan_a: assert property (tif.done ##1 tif.go |-> tif.sampling)
        else $error("next conversion did not follow at once");
endmodule

// [src/sas_pkg.sv]
// Types shared by the converter sequencer and its conversion timer.
package sas_pkg;
    // Operating mode decoded from the two mode bits.
    typedef enum logic [1:0] {SAS_SINGLE, SAS_MULTI, SAS_SCAN} sas_mode_t;
    // Phase of one conversion.
    typedef enum logic [1:0] {SAS_IDLE, SAS_DELAY, SAS_SAMPLE, SAS_CONVERT} sas_phase_t;
endpackage

// [src/sas_sequencer.sv]
// Register file, mode decode and channel sequencing of the converter.
`timescale 1ns/1ps
`include "sas_cfg.svh"
module sas_sequencer (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic standby,
    input wire logic [7:0] busAddr,
    input wire logic busRd,
    input wire logic busWr,
    input wire logic [7:0] busWdata,
    output logic [7:0] busRdata,
    input wire logic dmaXfer,
    input wire logic ext_trigger_pin,
    input wire logic [9:0] analogResult,
    output logic [2:0] analogChannel,
    output logic sampleHold,
    output logic convActive,
    output logic conv_end_irq
);
    // Control/status register fields.
    logic conv_end_flag;        // Set when a conversion run ends.
    logic end_irq_enable;       // Gates the end interrupt.
    logic conv_start_bit;       // High while conversion is wanted.
    logic multiSelect;          // Multi-channel select.
    logic conv_time_select;     // Fast conversion time when high.
    logic [2:0] channelSelect;  // Channel field, msb/mid/lsb.
    // Trigger/scan control register fields.
    logic ext_trigger_enable_hi; // Upper trigger enable.
    logic ext_trigger_enable_lo; // Lower trigger enable.
    logic continuous_scan_select; // Scan instead of multi.
    // Results, byte latch and sequencing state.
    logic [9:0] result [4];     // Result registers A to D.
    logic [7:0] lowLatch;       // Lower byte captured by an upper-byte read.
    logic flagSeen;             // Flag was read as one since the last write.
    logic [2:0] curChan;        // Channel being converted.
    logic trigSync1;            // First synchroniser stage.
    logic trigSync2;            // Second synchroniser stage.
    logic trigPrev;             // Delayed copy for edge detection.
    logic next_start;           // Start bit for the next cycle.
    logic next_flag;            // Flag for the next cycle.
    logic [7:0] rdMux;          // Read data selected by address.

    sas_timer_if tif ();

    sas_conv_timer u_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tif(tif.tmr)
    );

    // True for the even byte addresses of the result register window.
    function automatic logic isResult(input logic [7:0] addr);
        return addr[7:4] == `SAS_RES_BASE_NIB && !addr[0];
    endfunction

    // Result register index for an address.
    function automatic logic [1:0] resIndex(input logic [7:0] addr);
        return addr[3:2];
    endfunction

    // Inputs 4..7 go to A..D, inputs 2 and 3 share C and D.
    function automatic logic [1:0] chanIndex(input logic [2:0] chan);
        return chan[1:0];
    endfunction

    // Address decode.
    wire csrSel = busAddr == `SAS_OFF_CSR;
    wire trigSel = busAddr == `SAS_OFF_TRIG;
    wire csrWrite = busWr && csrSel;
    wire csrRead = busRd && csrSel;
    wire trigWrite = busWr && trigSel;
    wire resHiRead = busRd && isResult(busAddr) && !busAddr[1];
    wire resLoRead = busRd && isResult(busAddr) && busAddr[1];
    wire [1:0] rdIdx = resIndex(busAddr);
    wire [1:0] wrIdx = chanIndex(curChan);

    // Mode decode: scan select only matters with multi select set.
    wire sas_pkg::sas_mode_t mode = !multiSelect ? sas_pkg::SAS_SINGLE
        : (continuous_scan_select ? sas_pkg::SAS_SCAN : sas_pkg::SAS_MULTI);

    // Codes 000 and 001 are reserved and never start a conversion.
    wire reservedCode = channelSelect[2:1] == 2'b00;
    // Single mode converts the coded input; groups begin at input 2 or 4.
    wire [2:0] firstChan = (mode == sas_pkg::SAS_SINGLE) ? channelSelect
        : {channelSelect[2], ~channelSelect[2], 1'b0};
    // The code itself names the last channel of the group.
    wire atLast = curChan == channelSelect;
    wire endOfRun = tif.done && (mode == sas_pkg::SAS_SINGLE || atLast);

    // Trigger edge from the synchronised pin, enabled only by both bits.
    wire trigFall = trigPrev && !trigSync2;
    wire trigStart = trigFall && ext_trigger_enable_hi && ext_trigger_enable_lo;

    // A DMA read of any result register clears the end flag.
    wire dmaClear = dmaXfer && busRd && isResult(busAddr);
    // Software clears the flag by writing zero after reading it as one.
    wire swClear = csrWrite && !busWdata[`SAS_CSR_FLAG] && flagSeen;

    // Timer handshake.
    assign tif.go = conv_start_bit && !reservedCode;
    assign tif.fast = conv_time_select;

    // Outputs toward the analog core and the interrupt controller.
    assign analogChannel = curChan;
    assign sampleHold = tif.sampling;
    assign convActive = tif.go;
    assign conv_end_irq = conv_end_flag && end_irq_enable;

    // Start bit: hardware clears it at the end of a single or multi run, software writes it,
    // and a trigger edge sets it exactly as a software write of one would.
    always_comb begin
        next_start = conv_start_bit;
        if (endOfRun && mode != sas_pkg::SAS_SCAN) begin
            next_start = 1'b0;
        end
        if (conv_start_bit && reservedCode) begin
            next_start = 1'b0;
        end
        if (csrWrite) begin
            next_start = busWdata[`SAS_CSR_START];
        end
        if (trigStart) begin
            next_start = 1'b1;
        end
    end

    // End flag: a set in the same cycle as a clear wins.
    always_comb begin
        next_flag = conv_end_flag;
        if (swClear || dmaClear) begin
            next_flag = 1'b0;
        end
        if (endOfRun) begin
            next_flag = 1'b1;
        end
    end

    // Read data selection; unmapped addresses read zero.
    always_comb begin
        rdMux = 8'h00;
        if (csrSel) begin
            rdMux = {conv_end_flag, end_irq_enable, conv_start_bit, multiSelect,
                     conv_time_select, channelSelect};
        end else if (trigSel) begin
            // Bits 4 and 3 always read zero.
            rdMux = {ext_trigger_enable_hi, ext_trigger_enable_lo, continuous_scan_select,
                     2'b00, 3'b111};
        end else if (resHiRead) begin
            rdMux = result[rdIdx][9:2];
        end else if (resLoRead) begin
            rdMux = lowLatch;
        end
    end

    // Control/status register; standby acts like reset.
    always_ff @(posedge core_clk) begin
        if (!rst_b || standby) begin
            conv_end_flag <= 1'b0;
            end_irq_enable <= 1'b0;
            conv_start_bit <= 1'b0;
            multiSelect <= 1'b0;
            conv_time_select <= 1'b0;
            channelSelect <= 3'h0;
        end else begin
            conv_end_flag <= next_flag;
            conv_start_bit <= next_start;
            if (csrWrite) begin
                end_irq_enable <= busWdata[`SAS_CSR_IE];
                multiSelect <= busWdata[`SAS_CSR_MULTI];
                conv_time_select <= busWdata[`SAS_CSR_CKS];
                channelSelect <= busWdata[2:0];
            end
        end
    end

    // Trigger/scan control register; reserved bits are not stored.
    always_ff @(posedge core_clk) begin
        if (!rst_b || standby) begin
            ext_trigger_enable_hi <= 1'b0;
            ext_trigger_enable_lo <= 1'b0;
            continuous_scan_select <= 1'b0;
        end else if (trigWrite) begin
            ext_trigger_enable_hi <= busWdata[`SAS_TRIG_TE_HI];
            ext_trigger_enable_lo <= busWdata[`SAS_TRIG_TE_LO];
            continuous_scan_select <= busWdata[`SAS_TRIG_SCAN];
        end
    end

    // Flag-read tracker for the read-then-write clear sequence.
    always_ff @(posedge core_clk) begin
        if (!rst_b || standby) begin
            flagSeen <= 1'b0;
        end else if (csrRead && conv_end_flag) begin
            flagSeen <= 1'b1;
        end else if (csrWrite) begin
            flagSeen <= 1'b0;
        end
    end

    // Result registers written at the end of every conversion.
    always_ff @(posedge core_clk) begin
        if (!rst_b || standby) begin
            for (int i = 0; i < 4; i++) begin
                result[i] <= `SAS_RESULT_RESET;
            end
        end else if (tif.done) begin
            result[wrIdx] <= analogResult;
        end
    end

    // Lower-byte latch loaded by every upper-byte read.
    always_ff @(posedge core_clk) begin
        if (!rst_b || standby) begin
            lowLatch <= 8'h00;
        end else if (resHiRead) begin
            lowLatch <= {result[rdIdx][1:0], 6'h00};
        end
    end

    // Registered read data, held between reads.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            busRdata <= 8'h00;
        end else if (busRd) begin
            busRdata <= rdMux;
        end
    end

    // Channel pointer: parked on the first channel while the timer is idle,
    // stepped or wrapped at the end of each conversion.
    always_ff @(posedge core_clk) begin
        if (!rst_b || standby) begin
            curChan <= 3'h0;
        end else if (tif.idle) begin
            curChan <= firstChan;
        end else if (tif.done) begin
            curChan <= atLast ? firstChan : 3'(curChan + 3'h1);
        end
    end

    // Trigger pin synchroniser and edge history.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            trigSync1 <= 1'b1;
            trigSync2 <= 1'b1;
            trigPrev <= 1'b1;
        end else begin
            trigSync1 <= ext_trigger_pin;
            trigSync2 <= trigSync1;
            trigPrev <= trigSync2;
        end
    end

    default clocking scb @(posedge core_clk); endclocking
    default disable iff (!rst_b || standby);

    // Helper copy of result A for the latch check.
    wire [9:0] resA = result[0];
    sequence hiReadA;
        busRd && busAddr == `SAS_OFF_RES_A_HI;
    endsequence
    sequence loReadA;
        busRd && busAddr == `SAS_OFF_RES_A_LO;
    endsequence

    // A flag newly set with enable high raises the request.
    irq_request_a: assert property ($rose(conv_end_flag) && end_irq_enable |-> conv_end_irq)
        else $error("end interrupt not raised");
    // Single mode end stores, flags and stops together.
    single_end_a: assert property (tif.done && mode == sas_pkg::SAS_SINGLE && !csrWrite
        && !trigStart |=> !conv_start_bit && conv_end_flag)
        else $error("single conversion end incomplete");
    // Multi mode stops after its last channel.
    multi_stop_a: assert property (tif.done && mode == sas_pkg::SAS_MULTI && atLast
        && !csrWrite && !trigStart |=> !conv_start_bit && conv_end_flag)
        else $error("multi run did not stop");
    // Scan mode wraps to the first channel and keeps running.
    scan_wrap_a: assert property (tif.done && mode == sas_pkg::SAS_SCAN && atLast
        && !csrWrite |=> conv_start_bit && conv_end_flag && curChan == $past(firstChan))
        else $error("scan did not wrap");
    // An enabled trigger edge sets the start bit.
    trig_start_a: assert property (trigFall && ext_trigger_enable_hi && ext_trigger_enable_lo
        |=> conv_start_bit)
        else $error("trigger edge did not start");
    // A disabled trigger leaves an idle converter idle.
    trig_ignore_a: assert property (trigFall && !(ext_trigger_enable_hi && ext_trigger_enable_lo)
        && !conv_start_bit && !csrWrite |=> !conv_start_bit)
        else $error("disabled trigger started conversion");
    // Reserved trigger register bits 4 and 3 read as zero.
    reserved_zero_a: assert property (busRd && trigSel |=> busRdata[4:3] == 2'b00)
        else $error("reserved bits read nonzero");
    // Lower byte read after upper byte returns the latched bits.
    byte_latch_a: assert property (hiReadA ##1 loReadA
        |=> busRdata == {$past(resA[1:0], 2), 6'h00})
        else $error("lower byte latch mismatch");
    // The flag only falls after a read-then-write, a DMA read or a standby clear.
    flag_clear_a: assert property ($fell(conv_end_flag)
        |-> $past(swClear) || $past(dmaClear) || $past(standby))
        else $error("flag cleared without cause");
    // Clearing start during a conversion writes no flag.
    abort_quiet_a: assert property (csrWrite && !busWdata[`SAS_CSR_START] && !tif.done
        && !trigStart && !conv_end_flag |=> !conv_end_flag)
        else $error("abort still set the flag");
endmodule

// [src/sas_timer_if.sv]
// Handshake between the sequencer and its conversion timer.
`timescale 1ns/1ps
interface sas_timer_if;
    logic go;       // High while conversions are wanted.
    logic fast;     // Fast conversion time selected.
    logic idle;     // Timer waits for go.
    logic sampling; // Sample-and-hold is tracking the input.
    logic done;     // One-cycle pulse at the end of a conversion.
    modport seq (output go, output fast, input idle, input sampling, input done);
    modport tmr (input go, input fast, output idle, output sampling, output done);
endinterface

// [verif/sas_analog_model.sv]
// Behavioural analog core that answers each conversion with a channel-tagged code.
`timescale 1ns/1ps
module sas_analog_model (
    input wire logic core_clk,
    input wire logic [2:0] analogChannel,
    input wire logic sampleHold,
    output logic [9:0] analogResult
);
    logic heldPrev; // Sampling window state one cycle back.
    // Garbage that toggles every cycle while tracking, so a stale code cannot pass for a result.
    initial analogResult = 10'h3FF;
    always @(posedge core_clk) begin
        heldPrev <= sampleHold;
        if (sampleHold) begin
            analogResult <= ~analogResult;
        end else if (heldPrev) begin
            analogResult <= {analogChannel, 7'h55};
        end
    end
endmodule

// [verif/sas_sequencer_tb.sv]
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module sas_sequencer_tb;
    logic core_clk, rst_b, standby, busRd, busWr, dmaXfer, ext_trigger_pin;
    logic [7:0] busAddr, busWdata, busRdata, rv;
    logic [9:0] analogResult;
    logic [2:0] analogChannel;
    logic sampleHold, convActive, conv_end_irq;
    int nFail, testsRun, waited;
    sas_sequencer u_sas_sequencer (.core_clk(core_clk), .rst_b(rst_b), .standby(standby),
        .busAddr(busAddr), .busRd(busRd), .busWr(busWr), .busWdata(busWdata),
        .busRdata(busRdata), .dmaXfer(dmaXfer), .ext_trigger_pin(ext_trigger_pin),
        .analogResult(analogResult), .analogChannel(analogChannel),
        .sampleHold(sampleHold), .convActive(convActive), .conv_end_irq(conv_end_irq));
    sas_analog_model u_sas_analog_model (.core_clk(core_clk), .analogChannel(analogChannel),
        .sampleHold(sampleHold), .analogResult(analogResult));
    // Clock at 100 MHz.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic endOfTest();
        $display("checks %0d mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Compares one byte and reports a mismatch.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One write cycle, entered just after a rising edge; the next access lowers the strobe.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busRd = 1'b0;
        busAddr = a;
        busWdata = d;
        busWr = 1'b1;
        @(posedge core_clk);
        #1;
    endtask
    // One read cycle; data is settled just after the taking edge.
    task automatic rd(input logic [7:0] a);
        busWr = 1'b0;
        busAddr = a;
        busRd = 1'b1;
        @(posedge core_clk);
        #1;
        rv = busRdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        rd(a);
        chk(rv, exp, what);
    endtask
    // Polls the status register until bit b equals v, under a bound.
    task automatic waitBit(input int b, input logic v);
        for (waited = 0; waited < 3000; waited++) begin
            rd(8'h90);
            if (rv[b] === v) break;
        end
        if (waited == 3000) begin
            nFail++;
            $display("[FAIL] %0t status wait timed out", $time);
            endOfTest();
        end
    endtask
    // Runs one single conversion on input 2 and checks its length against lo..hi cycles.
    task automatic single(input logic [7:0] cmd, input int lo, input int hi);
        wr(8'h90, cmd);
        waitBit(7, 1'b1);
        chk(8'((waited >= lo) && (waited <= hi)), 8'h01, "conversion length");
        chk(rv, cmd ^ 8'hA0, "single end status");
        rdc(8'h88, 8'h55, "result C high");
        rdc(8'h8A, 8'h40, "result C low");
    endtask
    initial begin
        {standby, busRd, busWr, dmaXfer, busAddr, busWdata} = '0;
        ext_trigger_pin = 1'b1;
        rst_b = 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        rdc(8'h90, 8'h00, "status reset");
        rdc(8'h92, 8'h07, "trigger reset");
        rdc(8'h80, 8'h00, "result reset");
        wr(8'h92, 8'h00);
        rdc(8'h92, 8'h07, "reserved bits");
        $display("test registers done");
        single(8'h62, 512, 528);
        chk({7'h0, conv_end_irq}, 8'h01, "irq raised");
        wr(8'h90, 8'h40);
        rdc(8'h90, 8'h40, "flag cleared");
        chk({7'h0, conv_end_irq}, 8'h00, "irq dropped");
        single(8'h2A, 256, 270);
        $display("test single done");
        wr(8'h90, 8'h36);
        waitBit(5, 1'b0);
        chk(rv, 8'h96, "multi end status");
        chk({7'h0, conv_end_irq}, 8'h00, "irq masked");
        for (int k = 0; k < 3; k++) begin
            rdc(8'h80 + 8'(4 * k), {3'(4 + k), 5'h15}, "multi result high");
            rdc(8'h82 + 8'(4 * k), 8'h40, "multi result low");
        end
        rdc(8'h8C, 8'h00, "result D untouched");
        wr(8'h90, 8'h16);
        $display("test multi done");
        wr(8'h92, 8'h20);
        wr(8'h90, 8'h35);
        waitBit(7, 1'b1);
        chk(rv & 8'hA0, 8'hA0, "scan keeps start");
        wr(8'h90, 8'h15);
        repeat (300) rd(8'h90);
        chk(rv, 8'h15, "scan stopped");
        $display("test scan done");
        wr(8'h90, 8'h02);
        wr(8'h92, 8'h80);
        ext_trigger_pin = 1'b0;
        repeat (8) rd(8'h90);
        chk(rv, 8'h02, "trigger ignored");
        ext_trigger_pin = 1'b1;
        wr(8'h92, 8'hC0);
        repeat (4) rd(8'h90);
        ext_trigger_pin = 1'b0;
        waitBit(7, 1'b1);
        chk(rv, 8'h82, "trigger start");
        dmaXfer = 1'b1;
        rdc(8'h88, 8'h55, "trigger result");
        dmaXfer = 1'b0;
        rdc(8'h90, 8'h02, "dma read clears flag");
        {standby, busRd} = 2'b10;
        @(posedge core_clk);
        #1;
        standby = 1'b0;
        rdc(8'h92, 8'h07, "standby trigger");
        rdc(8'h88, 8'h00, "standby result");
        $display("test trigger done");
        endOfTest();
    end
endmodule
